/* File: hw/bwc_top.sv */
// block write command interpreter with protection generate and check
// What this block does
// - opcode 2Ah: lba bytes 2-5, count 7-8
// - opcode AAh: lba bytes 2-5, count 6-9
// - low priority bit forces lowest retention
// - force write: media done before good status
// - without force, good status may precede media
// - zero count seeks, moves nothing, no error
// - generated guard is crc over block
// - type 1 ref tag is low lba
// - type 2 ref tag is 0FFFFFFF
// - app tag FFFF when owner bit set
// - unformatted with nonzero mode is illegal
// - mode 000 device generates protection
// - mode 001 checks guard and ref
// - mode 010 checks ref only
// - mode 011 checks nothing
// - mode 100 checks guard only
// - modes 101-111 rejected as invalid field
// - failed check aborts with pi sense
module bwc_top import bwc_pkg::*; #(
  parameter int BLK_WORDS = WORDS_PER_BLK
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [95:0]  cdb,
  input  wire logic         cdbValid,
  output logic              cdbReady,
  input  wire logic         protection_enabled,
  input  wire logic [2:0]   protectionType,
  input  wire logic         application_tag_owner,
  input  wire logic [1:0]   cfgRetention,
  input  wire logic [31:0]  hostData,
  input  wire logic         hostValid,
  output logic              hostReady,
  output logic [31:0]       mediaData,
  output logic              mediaValid,
  input  wire logic         mediaReady,
  input  wire logic         mediaFlushDone,
  output logic [31:0]       cmdLba,
  output logic              cmdSeek,
  output logic [1:0]        cmdRetention,
  output logic              cmdDone,
  output logic [7:0]        cmdStatus,
  output logic [3:0]        senseKey,
  output logic [7:0]        senseCode,
  output logic [7:0]        senseQual
);
  bwc_state_t  state;
  logic [7:0]  b [CDB_BYTES];
  logic [31:0] blocksLeft;
  logic [31:0] wordIdx;
  logic [31:0] curLba;
  logic [2:0]  mode;
  logic        forceWrite;
  logic        hostPi;
  logic        chkGuard;
  logic        chkRef;
  logic        piIdx;
  logic [15:0] crcVal;
  logic        crcClear;
  logic        crcStep;
  logic [31:0] piWord;
  logic [31:0] bufIn;
  logic        bufValid;
  logic        bufReady;
  logic        flushSync1;
  logic        flushSync2;
  logic        cmdIsW10;
  logic        cmdIsW12;
  logic        moveWord;
  logic        lastWord;
  logic [15:0] appTag;
  logic [31:0] refTag;

  // ****************************************
  // command block fields
  // ****************************************
  // byte 0 of the command block sits at the top end of the vector
  for (genvar i = 0; i < CDB_BYTES; i++) begin : g_byte
    assign b[i] = cdb[95-8*i -: 8];
  end
  // only the short and long write forms are decoded here
  assign cmdIsW10 = (b[0] == OP_WRITE10);
  assign cmdIsW12 = (b[0] == OP_WRITE12);

  // flush completion comes from the media side, outside this clock
  // two stages cost two cycles of latency but give a clean level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flushSync1 <= 1'b0;
      flushSync2 <= 1'b0;
    end else if (ce) begin
      flushSync1 <= mediaFlushDone;
      flushSync2 <= flushSync1;
    end
  end

  // ****************************************
  // data path: host words, then generated or host pi
  // ****************************************
  // app tag is don't care when not owned; ffff chosen for both
  assign appTag = application_tag_owner ? APP_OWNED : APP_OWNED;
  // type 1 follows the block address, type 2 a fixed tag
  assign refTag = (protectionType == PTYPE_2) ? REF_TYPE2
                                             : curLba;
  // first pi word holds guard and app tag, the second the ref tag
  assign piWord = piIdx ? refTag : {crcVal, appTag};
  // generated pi words enter the buffer without a host handshake
  assign bufIn  = (state == BWC_PI) ? piWord : hostData;
  assign bufValid = (state == BWC_DATA && hostValid)
                 || (state == BWC_PI && !hostPi);
  // host pi words arrive in place of generated ones
  assign hostReady = ((state == BWC_DATA) || (state == BWC_PI && hostPi))
                   && bufReady;
  // one word moves per cycle when both ends agree
  assign moveWord = ce && (((state == BWC_DATA) && hostValid && bufReady)
                 || ((state == BWC_PI) && (hostPi ? hostValid : 1'b1)
                     && bufReady));
  // the word counter wraps at the end of each block's data
  assign lastWord = (wordIdx == 32'(BLK_WORDS - 1));
  // guard restarts after each block's second pi word; idle clears it as well
  assign crcClear = (state == BWC_IDLE) || (state == BWC_PI && moveWord
                                            && piIdx);
  assign crcStep  = (state == BWC_DATA) && moveWord;

  // ****************************************
  // guard crc and data buffer
  // ****************************************
  // the guard only ever sees host data words, never pi words
  bwc_crc u_crc (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .clear (crcClear),
    .step  (crcStep),
    .word  (hostData),
    .crc   (crcVal)
  );

  // stall at the media end backs up into host ready
  // two entries keep full rate while media ready toggles
  bwc_skid #(.W(32)) u_buf (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .inData   ((state == BWC_PI && hostPi) ? hostData : bufIn),
    .inValid  (bufValid || (state == BWC_PI && hostPi && hostValid)),
    .inReady  (bufReady),
    .outData  (mediaData),
    .outValid (mediaValid),
    .outReady (mediaReady)
  );

  // ****************************************
  // command sequencer
  // ****************************************
  // one process owns the command state and its status outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= BWC_IDLE;
      cdbReady     <= 1'b0;
      blocksLeft   <= 32'h0000_0000;
      wordIdx      <= 32'h0000_0000;
      curLba       <= 32'h0000_0000;
      mode         <= PCM_NONE;
      forceWrite   <= 1'b0;
      hostPi       <= 1'b0;
      chkGuard     <= 1'b0;
      chkRef       <= 1'b0;
      piIdx        <= 1'b0;
      cmdLba       <= 32'h0000_0000;
      cmdSeek      <= 1'b0;
      cmdRetention <= RET_LOWEST;
      cmdDone      <= 1'b0;
      // status reads good until the first command ends
      cmdStatus    <= ST_GOOD;
      senseKey     <= SK_NONE;
      senseCode    <= ASC_NONE;
      senseQual    <= ASCQ_NONE;
    end else if (ce) begin
      // pulses drop back after one cycle unless set again below
      cmdDone  <= 1'b0;
      cmdSeek  <= 1'b0;
      cdbReady <= (state == BWC_IDLE);
      case (state)
        BWC_IDLE: begin
          if (cdbValid && cdbReady) begin
            // capture every field at the take; the block may change later
            cdbReady   <= 1'b0;
            mode       <= b[1][MODE_MSB:MODE_LSB];
            forceWrite <= b[1][FMW_BIT];
            cmdRetention <= b[1][CLP_BIT] ? RET_LOWEST
                                          : cfgRetention;
            curLba     <= {b[2], b[3], b[4], b[5]};
            cmdLba     <= {b[2], b[3], b[4], b[5]};
            hostPi     <= (b[1][MODE_MSB:MODE_LSB] != PCM_NONE);
            chkGuard   <= (b[1][MODE_MSB:MODE_LSB] == PCM_ALL)
                       || (b[1][MODE_MSB:MODE_LSB] == PCM_GUARD);
            chkRef     <= (b[1][MODE_MSB:MODE_LSB] == PCM_ALL)
                       || (b[1][MODE_MSB:MODE_LSB] == PCM_REF);
            wordIdx    <= 32'h0000_0000;
            piIdx      <= 1'b0;
            cmdStatus  <= ST_GOOD;
            senseKey   <= SK_NONE;
            senseCode  <= ASC_NONE;
            senseQual  <= ASCQ_NONE;
            // the count is 16 bits in the short form, 32 in the long
            if (cmdIsW10) begin
              blocksLeft <= {16'h0000, b[7], b[8]};
            end else begin
              blocksLeft <= {b[6], b[7], b[8], b[9]};
            end
            // refusals skip the seek and go straight to status
            if (!cmdIsW10 && !cmdIsW12) begin
              cmdStatus <= ST_CHECK;
              senseKey  <= SK_ILLEGAL;
              senseCode <= ASC_BADOP;
              state     <= BWC_DONE;
            end else if (b[1][MODE_MSB:MODE_LSB] > PCM_GUARD
                         || (!protection_enabled
                             && b[1][MODE_MSB:MODE_LSB] != PCM_NONE)) begin
              cmdStatus <= ST_CHECK;
              senseKey  <= SK_ILLEGAL;
              senseCode <= ASC_BADFIELD;
              state     <= BWC_DONE;
            end else begin
              state <= BWC_SEEK;
            end
          end
        end
        BWC_SEEK: begin
          // a zero count still seeks but moves no data
          cmdSeek <= 1'b1;
          state   <= (blocksLeft == 32'h0000_0000) ? BWC_DONE : BWC_DATA;
        end
        BWC_DATA: begin
          if (moveWord) begin
            wordIdx <= wordIdx + 32'h0000_0001;
            if (lastWord) begin
              wordIdx <= 32'h0000_0000;
              // without protection a block ends with its last data word
              if (protection_enabled) begin
                state <= BWC_PI;
              end else begin
                blocksLeft <= blocksLeft - 32'h0000_0001;
                curLba     <= curLba + 32'h0000_0001;
                if (blocksLeft == 32'h0000_0001) begin
                  state <= forceWrite ? BWC_FLUSH : BWC_DONE;
                end
              end
            end
          end
        end
        BWC_PI: begin
          if (moveWord) begin
            piIdx <= ~piIdx;
            // a failed check ends the command; later words are ignored
            // guard sits in upper half of the first pi word
            if (!piIdx && chkGuard && hostData[31:16] != crcVal) begin
              cmdStatus <= ST_CHECK;
              senseKey  <= SK_ABORTED;
              senseCode <= ASC_PI;
              senseQual <= ASCQ_GUARD;
              state     <= BWC_DONE;
            end else if (piIdx && chkRef && hostData != refTag) begin
              cmdStatus <= ST_CHECK;
              senseKey  <= SK_ABORTED;
              senseCode <= ASC_PI;
              senseQual <= ASCQ_REF;
              state     <= BWC_DONE;
              // both pi words passed: the block is complete
            end else if (piIdx) begin
              blocksLeft <= blocksLeft - 32'h0000_0001;
              curLba     <= curLba + 32'h0000_0001;
              if (blocksLeft == 32'h0000_0001) begin
                state <= forceWrite ? BWC_FLUSH : BWC_DONE;
              end else begin
                state <= BWC_DATA;
              end
            end
          end
        end
        BWC_FLUSH: begin
          // good status held until media and buffer are both drained
          if (flushSync2 && !mediaValid) begin
            state <= BWC_DONE;
          end
        end
        BWC_DONE: begin
          // one-cycle done pulse; status holds until the next take
          cmdDone <= 1'b1;
          state   <= BWC_IDLE;
        end
        default: begin
          // an illegal state code recovers to idle
          state <= BWC_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: hw/bwc_pkg.sv */
// package: constants and types for the block write command handler
package bwc_pkg;
  // ****************************************
  // command codes and field positions
  // ****************************************
  localparam logic [7:0] OP_WRITE10   = 8'h2a;
  localparam logic [7:0] OP_WRITE12   = 8'haa;
  localparam int         MODE_MSB     = 7;
  localparam int         MODE_LSB     = 5;
  localparam int         CLP_BIT      = 4;
  localparam int         FMW_BIT      = 3;
  localparam int         CDB_BYTES    = 12;
  // ****************************************
  // protection check modes and types
  // ****************************************
  localparam logic [2:0] PCM_NONE     = 3'h0;
  localparam logic [2:0] PCM_ALL      = 3'h1;
  localparam logic [2:0] PCM_REF      = 3'h2;
  localparam logic [2:0] PCM_NOCHK    = 3'h3;
  localparam logic [2:0] PCM_GUARD    = 3'h4;
  localparam logic [2:0] PTYPE_1      = 3'h0;
  localparam logic [2:0] PTYPE_2      = 3'h1;
  localparam logic [31:0] REF_TYPE2   = 32'h0fff_ffff;
  localparam logic [15:0] APP_OWNED   = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'h8bb7;
  localparam logic [15:0] CRC_INIT    = 16'h0000;
  // ****************************************
  // status and sense codes
  // ****************************************
  localparam logic [7:0] ST_GOOD      = 8'h00;
  localparam logic [7:0] ST_CHECK     = 8'h02;
  localparam logic [3:0] SK_NONE      = 4'h0;
  localparam logic [3:0] SK_ILLEGAL   = 4'h5;
  localparam logic [3:0] SK_ABORTED   = 4'hb;
  localparam logic [7:0] ASC_NONE     = 8'h00;
  localparam logic [7:0] ASC_BADFIELD = 8'h24;
  localparam logic [7:0] ASC_BADOP    = 8'h20;
  localparam logic [7:0] ASC_PI       = 8'h10;
  localparam logic [7:0] ASCQ_GUARD   = 8'h01;
  localparam logic [7:0] ASCQ_APP     = 8'h02;
  localparam logic [7:0] ASCQ_REF     = 8'h03;
  localparam logic [7:0] ASCQ_NONE    = 8'h00;
  localparam logic [1:0] RET_LOWEST   = 2'h0;
  localparam int         WORDS_PER_BLK = 128;
  typedef enum logic [5:0] {
    BWC_IDLE  = 6'b00_0001,
    BWC_DATA  = 6'b00_0010,
    BWC_PI    = 6'b00_0100,
    BWC_FLUSH = 6'b00_1000,
    BWC_DONE  = 6'b01_0000,
    BWC_SEEK  = 6'b10_0000
  } bwc_state_t;
endpackage

/* File: hw/bwc_skid.sv */
// two-entry buffer with valid/ready on both sides
module bwc_skid import bwc_pkg::*; #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  output logic [W-1:0]      outData,
  output logic              outValid,
  input  wire logic         outReady
);
  logic [W-1:0] mem [2];
  logic         wrPtr;
  logic         rdPtr;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  // ****************************************
  // storage
  // ****************************************
  assign inReady  = (count != 2'd2);
  assign outValid = (count != 2'd0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady && ce;
  assign pop      = outValid && outReady && ce;

  // every pushed word is written into the entry at the write pointer
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (push) begin
        wrPtr <= ~wrPtr;
      end
      if (pop) begin
        rdPtr <= ~rdPtr;
      end
      count <= count + 2'(push) - 2'(pop);
    end
  end
endmodule

/* File: hw/bwc_crc.sv */
// guard crc accumulator over 32-bit words, msb first
module bwc_crc import bwc_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic [31:0] word,
  output logic [15:0]      crc
);
  logic [15:0] next_crc;

  // one word folds in per step; a loop keeps the per-bit logic compact
  always_comb begin
    next_crc = crc;
    for (int i = 31; i >= 0; i--) begin
      if (next_crc[15] ^ word[i]) begin
        next_crc = {next_crc[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        next_crc = {next_crc[14:0], 1'b0};
      end
    end
  end

  // accumulator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= CRC_INIT;
    end else if (ce) begin
      if (clear) begin
        crc <= CRC_INIT;
      end else if (step) begin
        crc <= next_crc;
      end
    end
  end
endmodule

/* File: bench/bwc_top_monitor.sv */
// checker for the port timing and status of the write command block
module bwc_top_monitor import bwc_pkg::*; #(
  parameter int BLK_WORDS = WORDS_PER_BLK
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [95:0] cdb,
  input wire logic        cdbValid,
  input wire logic        cdbReady,
  input wire logic        protection_enabled,
  input wire logic [1:0]  cfgRetention,
  input wire logic [31:0] mediaData,
  input wire logic        mediaValid,
  input wire logic        mediaReady,
  input wire logic        mediaFlushDone,
  input wire logic [31:0] cmdLba,
  input wire logic        cmdSeek,
  input wire logic [1:0]  cmdRetention,
  input wire logic        cmdDone,
  input wire logic [7:0]  cmdStatus,
  input wire logic [3:0]  senseKey,
  input wire logic [7:0]  senseCode
);
  logic take, opOk, badMode, zeroLen, fmwHeld;
  // ****************************************
  // decode of the command block at the take edge
  // ****************************************
  assign take = cdbValid && cdbReady && ce;
  assign opOk = cdb[95:88] == OP_WRITE10 || cdb[95:88] == OP_WRITE12;
  assign badMode = cdb[87:85] > PCM_GUARD ||
                   (!protection_enabled && cdb[87:85] != PCM_NONE);
  assign zeroLen = cdb[95:88] == OP_WRITE12 ? cdb[47:16] == 32'h0
                                            : cdb[39:24] == 16'h0;
  // keep the force bit; a zero count has nothing to commit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fmwHeld <= 1'b0;
    else if (take) fmwHeld <= cdb[80 + FMW_BIT] && !zeroLen;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence seek_s; ##2 cmdSeek; endsequence
  sequence zero_done_s; seek_s ##1 (cmdDone && cmdStatus == ST_GOOD);
  endsequence
  bad_op_a: assert property (take && !opOk |-> ##2 (cmdDone &&
    cmdStatus == ST_CHECK && senseKey == SK_ILLEGAL &&
    senseCode == ASC_BADOP)) else $error("unknown opcode not refused");
  bad_field_a: assert property (take && opOk && badMode |->
    ##2 (cmdDone && cmdStatus == ST_CHECK && senseKey == SK_ILLEGAL &&
    senseCode == ASC_BADFIELD)) else $error("bad mode not refused");
  seek_start_a: assert property (take && opOk && !badMode
    |-> seek_s) else $error("no seek after command");
  zero_len_a: assert property (take && opOk && !badMode && zeroLen
    |-> zero_done_s) else $error("zero count not done good");
  seek_lba_a: assert property (cmdSeek |->
    cmdLba == $past(cdb[79:48], 2)) else $error("seek address wrong");
  low_prio_a: assert property (cmdSeek |-> cmdRetention ==
    ($past(cdb[84], 2) ? RET_LOWEST : cfgRetention))
    else $error("retention wrong");
  media_hold_a: assert property (mediaValid && !mediaReady |=>
    mediaValid && $stable(mediaData)) else $error("media word dropped");
  force_done_a: assert property (cmdDone && fmwHeld &&
    cmdStatus == ST_GOOD |-> !mediaValid && $past(mediaFlushDone, 2))
    else $error("good status before media commit");
endmodule

bind bwc_top bwc_top_monitor #(.BLK_WORDS(BLK_WORDS)) mon (
  .clk(clk), .rst_n(rst_n), .ce(ce), .cdb(cdb), .cdbValid(cdbValid),
  .cdbReady(cdbReady), .protection_enabled(protection_enabled),
  .cfgRetention(cfgRetention), .mediaData(mediaData),
  .mediaValid(mediaValid), .mediaReady(mediaReady),
  .mediaFlushDone(mediaFlushDone), .cmdLba(cmdLba), .cmdSeek(cmdSeek),
  .cmdRetention(cmdRetention), .cmdDone(cmdDone), .cmdStatus(cmdStatus),
  .senseKey(senseKey), .senseCode(senseCode));

/* File: bench/bwc_host_model.sv */
// host side model: feeds the words of a command with random stalls
module bwc_host_model (
  input  wire logic        clk,
  input  wire logic        hostReady,
  output logic [31:0]      hostData,
  output logic             hostValid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] q[$];
  logic        acc;
  int          sd = 32'h0000_0b5d;
  initial begin
    hostValid = 1'b0;
    hostData = 32'h0000_0000;
  end
  // only data in mode 000, data plus two pi words otherwise; a word
  // stays until taken, and idle lines toggle so no stale value lingers
  always @(posedge clk) begin
    acc = hostValid && hostReady;
    #1;
    if (acc) void'(q.pop_front());
    if (!hostValid || acc) begin
      hostValid = q.size() > 0 && $random(sd) % 4 != 0;
      hostData = hostValid ? q[0] : ~hostData;
    end
  end
  // an aborted command leaves words behind; drop them
  task automatic clear();
    q.delete();
    hostValid = 1'b0;
  endtask
endmodule

/* File: bench/bwc_top_tb_top.sv */
// testbench for the block write command interpreter
module bwc_top_tb_top import bwc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BW = 4;
  logic        clk = 1'b0, rst_n = 1'b0, cdbV = 1'b0, pe = 1'b0;
  logic        mR = 1'b0, flush = 1'b0, cdbR, hV, hR, mV, seek, done;
  logic [95:0] cdb = 96'h0;
  logic [2:0]  pt = 3'h0;
  logic [1:0]  cfgRet = 2'h0, ret;
  logic [31:0] hD, mD, lba, mq[$], eq[$];
  logic [7:0]  st, sc, sq;
  logic [3:0]  sk;
  logic        doneSeen, seekSeen;
  int          error_cnt = 0, cmp_count = 0, seed = 32'h0000_6460;
  bwc_top #(.BLK_WORDS(BW)) dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .cdb(cdb), .cdbValid(cdbV),
    .cdbReady(cdbR), .protection_enabled(pe), .protectionType(pt),
    .application_tag_owner(1'b1), .cfgRetention(cfgRet), .hostData(hD),
    .hostValid(hV), .hostReady(hR), .mediaData(mD), .mediaValid(mV),
    .mediaReady(mR), .mediaFlushDone(flush), .cmdLba(lba), .cmdSeek(seek),
    .cmdRetention(ret), .cmdDone(done), .cmdStatus(st), .senseKey(sk),
    .senseCode(sc), .senseQual(sq));
  bwc_host_model host (.clk(clk), .hostReady(hR), .hostData(hD),
    .hostValid(hV));
  always #5 clk = ~clk;
  // media end stalls at random so the buffer fills; pulses are latched
  always @(posedge clk) begin
    if (mV && mR) mq.push_back(mD);
    if (done === 1'b1) doneSeen = 1'b1;
    if (seek === 1'b1) seekSeen = 1'b1;
    #1 mR = $random(seed) % 3 != 0;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // a wait that used up its bound ends the run as a failure
  task automatic lapse(input logic hung);
    if (hung) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_st(input logic [27:0] g, input logic [27:0] e);
    chk({4'h0, g}, {4'h0, e});
  endtask
  // guard crc, msb first over one word
  function automatic logic [15:0] crc_w(input logic [15:0] c,
                                        input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  // status, key, code and qualifier expected for a command
  function automatic logic [27:0] exp_st(input logic [7:0] op,
    input logic [2:0] m, input logic p, input int bad);
    if (op != OP_WRITE10 && op != OP_WRITE12)
      return {ST_CHECK, SK_ILLEGAL, ASC_BADOP, ASCQ_NONE};
    if (m > PCM_GUARD || (!p && m != PCM_NONE))
      return {ST_CHECK, SK_ILLEGAL, ASC_BADFIELD, ASCQ_NONE};
    if (bad == 1 && (m == PCM_ALL || m == PCM_GUARD))
      return {ST_CHECK, SK_ABORTED, ASC_PI, ASCQ_GUARD};
    if (bad == 2 && (m == PCM_ALL || m == PCM_REF))
      return {ST_CHECK, SK_ABORTED, ASC_PI, ASCQ_REF};
    return {ST_GOOD, SK_NONE, ASC_NONE, ASCQ_NONE};
  endfunction
  // one command: bad 1 spoils the guard, bad 2 the reference tag
  task automatic run(input logic [7:0] op, input logic [2:0] m,
    input logic p, input logic [2:0] t, input logic clp, input logic fmw,
    input logic [31:0] a, input logic [31:0] n, input int bad);
    logic [27:0] es;
    logic [15:0] g;
    logic [31:0] w;
    int          k;
    es = exp_st(op, m, p, bad);
    eq.delete();
    pe = p;
    pt = t;
    cfgRet = 2'($random(seed));
    cdb = {op, m, clp, fmw, 3'h0, a, op == OP_WRITE12 ? {n, 16'h0000}
          : {8'h00, n[15:0], 24'h00_0000}};
    for (int b = 0; b < n && es[19:16] != SK_ILLEGAL; b++) begin
      g = CRC_INIT;
      for (int i = 0; i < BW; i++) begin
        w = $random(seed);
        g = crc_w(g, w);
        host.q.push_back(w);
        eq.push_back(w);
      end
      if (p) begin
        eq.push_back({g ^ 16'(bad == 1), APP_OWNED});
        eq.push_back((t == PTYPE_2 ? REF_TYPE2 : a + b)
          ^ 32'(bad == 2));
        if (m != PCM_NONE) begin
          host.q.push_back(eq[$-1]);
          host.q.push_back(eq[$]);
        end
      end
    end
    mq.delete();
    doneSeen = 1'b0;
    seekSeen = 1'b0;
    for (k = 0; k < 50 && cdbR !== 1'b1; k++) tick();
    lapse(cdbR !== 1'b1);
    cdbV = 1'b1;
    tick();
    cdbV = 1'b0;
    if (fmw && es[27:20] == ST_GOOD) begin
      for (k = 0; k < 3000 && mq.size() < eq.size(); k++) tick();
      lapse(mq.size() < eq.size());
      repeat (10) tick();
      chk({31'h0, doneSeen}, 32'h0);
      flush = 1'b1;
    end
    for (k = 0; k < 3000 && !doneSeen; k++) tick();
    flush = 1'b0;
    lapse(!doneSeen);
    chk_st({st, sk, sc, sq}, es);
    if (es[27:20] == ST_GOOD) begin
      for (k = 0; k < 3000 && mq.size() < eq.size(); k++) tick();
      lapse(mq.size() < eq.size());
      chk({31'h0, seekSeen}, 32'h1);
      chk(lba, a);
      chk({30'h0, ret}, {30'h0, clp ? RET_LOWEST : cfgRet});
      chk(32'(mq.size()), 32'(eq.size()));
      foreach (eq[i]) chk(mq[i], eq[i]);
    end
    if (es[19:16] == SK_ILLEGAL) chk({31'h0, seekSeen}, 32'h0);
    host.clear();
    repeat (8) tick();
    $display("command %h mode %0d blocks %0d done", op, m, n);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] rv;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    tick();
    tick();
    run(OP_WRITE10, PCM_NONE, 1, PTYPE_1, 1, 0,
      32'hffff_fffe, 2, 0);
    run(OP_WRITE12, PCM_NONE, 1, PTYPE_2, 0, 1,
      32'h0001_0000, 1, 0);
    run(OP_WRITE12, PCM_NONE, 0, PTYPE_1, 1, 0,
      32'h0000_0040, 3, 0);
    run(OP_WRITE10, PCM_NONE, 1, PTYPE_1, 0, 0,
      32'h0000_0010, 0, 0);
    run(8'h28, PCM_NONE, 1, PTYPE_1, 0, 0, 32'h0, 1, 0);
    for (int m = 1; m < 8; m++) begin
      run(OP_WRITE10, 3'(m), 0, PTYPE_1, 0, 0, 32'h0, 1, 0);
      for (int b = 0; b < 3; b++)
        run(OP_WRITE12, 3'(m), 1, 3'(b % 2), 0, 0, 32'(m * 64), 1,
          b);
    end
    // random legal commands; low priority set at random
    for (int r = 0; r < 12; r++) begin
      rv = $random(seed);
      run(rv[0] ? OP_WRITE12 : OP_WRITE10, 3'(rv[3:1] % 5), 1'b1,
        3'(rv[4]), rv[5], rv[6] && rv[8:7] != 0, $random(seed),
        {30'h0, rv[8:7]}, 0);
    end
    give_verdict();
  end
endmodule
